// file: logic/asc_sampling_clamp_ctrl.sv
// Sampling mode, input clamp, clamp window, line sync and analog gain control for four channels
// Function
// - Per-channel input polarity select bit
// - Double sampling: reference then data per pixel
// - Sample-hold uses only the data pulse
// - Clamp mode held per channel
// - Unclamped 2 internal, 3 external ground reference
// - Line clamp uses reference pulse inside window
// - No line clamp while in sample-hold
// - Window start/end counted from sync falling edge
// - Group A serves channels 1-2, B 3-4
// - Clamp pulse starts at reference pulse rise
// - Clamp width half reference, or programmed end
// - Pixel clamp inside window uses reference pulse
// - Clamp window high after reset until enabled
// - Register offsets 7,8,9,16,17 and 399 bit 1
// - Per-channel clamp level source among three
// - Internal line sync after count, one cycle
`timescale 1ns/10ps
`default_nettype none
`include "asc_cfg.svh"

module asc_sampling_clamp_ctrl #(
   parameter int PIX_W = 8
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [9:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic ext_line_sync,
   output logic line_sync,
   output logic clamp_window,
   output logic [1:0] ref_sample_pulse,
   output logic [1:0] data_sample_pulse,
   output logic clamp_pulse_group_a,
   output logic clamp_pulse_group_b,
   output asc_pkg::asc_chan_t chan_ctl [4]
);

   // Software-visible registers
   logic [15:0] line_len_r;
   logic [15:0] win_start_r;
   logic [15:0] win_end_r;
   logic [PIX_W-1:0] clp_end_r;
   logic [15:0] pix_tim_r;
   logic [PIX_W-1:0] pix_per_r;
   logic [15:0] clp_sel_r [2];
   logic [15:0] chan_cfg_r [4];
   logic [2:0] misc_r;

   // Timing state
   logic [15:0] lcnt_r;
   logic sync_q1_r;
   logic sync_q2_r;
   logic [2:0] xhi_cnt_r;
   logic line_sync_r;
   logic sync_dly_r;
   logic [PIX_W-1:0] ph_r;
   logic [15:0] pix_cnt_r;
   logic ref_r;
   logic data_r;
   logic clp_on_r;
   logic [PIX_W-1:0] clp_cnt_r;
   logic win_r;

   // Address decode
   wire logic wr_line_len = reg_wr && (reg_addr == `ASC_OFF_LINE_LEN);
   wire logic wr_win_start = reg_wr && (reg_addr == `ASC_OFF_WIN_START);
   wire logic wr_win_end = reg_wr && (reg_addr == `ASC_OFF_WIN_END);
   wire logic wr_clp_end = reg_wr && (reg_addr == `ASC_OFF_CLP_END);
   wire logic wr_pix_tim = reg_wr && (reg_addr == `ASC_OFF_PIX_TIM);
   wire logic wr_pix_per = reg_wr && (reg_addr == `ASC_OFF_PIX_PER);
   wire logic wr_misc = reg_wr && (reg_addr == `ASC_OFF_MISC);

   // Pixel timing fields
   wire logic [3:0] ref_start = pix_tim_r[3:0];
   wire logic [3:0] ref_width = pix_tim_r[7:4];
   wire logic [3:0] dat_start = pix_tim_r[11:8];
   wire logic [3:0] dat_width = pix_tim_r[15:12];
   wire logic auto_dis = misc_r[`ASC_MISC_AUTO_DIS];
   wire logic win_en = misc_r[`ASC_MISC_WIN_EN];
   wire logic sync_ext = ~misc_r[`ASC_MISC_SYNC_SRC];

   // Field extraction of a channel's clamp select byte
   function automatic logic [7:0] clp_field(input logic [15:0] lo, input logic [15:0] hi, input int ch);
      logic [15:0] w;
      w = (ch < 2) ? lo : hi;
      clp_field = (ch % 2 == 0) ? w[7:0] : w[15:8];
   endfunction

   // Register writes; a zero manual end is read as a one-cycle width
   always_ff @(posedge clk) begin
      if (reset) begin
         line_len_r <= `ASC_RST_LINE_LEN;
         win_start_r <= `ASC_RST_ZERO16;
         win_end_r <= `ASC_RST_ZERO16;
         clp_end_r <= PIX_W'(`ASC_RST_CLP_END);
         pix_tim_r <= `ASC_RST_PIX_TIM;
         pix_per_r <= PIX_W'(`ASC_RST_PIX_PER);
         misc_r <= 3'h0;
      end else begin
         if (wr_line_len) line_len_r <= reg_wdata;
         if (wr_win_start) win_start_r <= reg_wdata;
         if (wr_win_end) win_end_r <= reg_wdata;
         if (wr_clp_end) clp_end_r <= reg_wdata[PIX_W-1:0];
         if (wr_pix_tim) pix_tim_r <= reg_wdata;
         if (wr_pix_per) pix_per_r <= reg_wdata[PIX_W-1:0];
         if (wr_misc) misc_r <= reg_wdata[2:0];
      end
   end

   // Clamp select registers, one byte per channel
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_clp_sel
         always_ff @(posedge clk) begin
            if (reset) begin
               clp_sel_r[g] <= `ASC_RST_ZERO16;
            end else if (reg_wr && (reg_addr == `ASC_OFF_CLP_SEL_LO + 10'(g))) begin
               clp_sel_r[g] <= reg_wdata;
            end
         end
      end
      for (g = 0; g < 4; g++) begin : g_chan_cfg
         always_ff @(posedge clk) begin
            if (reset) begin
               chan_cfg_r[g] <= `ASC_RST_ZERO16;
            end else if (reg_wr && (reg_addr == `ASC_OFF_CHAN_CFG0 + 10'(g))) begin
               chan_cfg_r[g] <= reg_wdata;
            end
         end
      end
   endgenerate

   // Read mux; unmapped addresses return zero
   logic [15:0] rd_mux;
   always_comb begin
      rd_mux = 16'h0000;
      if (reg_addr == `ASC_OFF_LINE_LEN) rd_mux = line_len_r;
      else if (reg_addr == `ASC_OFF_WIN_START) rd_mux = win_start_r;
      else if (reg_addr == `ASC_OFF_WIN_END) rd_mux = win_end_r;
      else if (reg_addr == `ASC_OFF_CLP_END) rd_mux = 16'(clp_end_r);
      else if (reg_addr == `ASC_OFF_PIX_TIM) rd_mux = pix_tim_r;
      else if (reg_addr == `ASC_OFF_PIX_PER) rd_mux = 16'(pix_per_r);
      else if (reg_addr == `ASC_OFF_STATUS) rd_mux = {13'h0000, sync_q2_r, clp_on_r, win_r};
      else if (reg_addr == `ASC_OFF_PIX_CNT) rd_mux = pix_cnt_r;
      else if (reg_addr == `ASC_OFF_CLP_SEL_LO) rd_mux = clp_sel_r[0];
      else if (reg_addr == `ASC_OFF_CLP_SEL_HI) rd_mux = clp_sel_r[1];
      else if (reg_addr >= `ASC_OFF_CHAN_CFG0 && reg_addr < `ASC_OFF_CHAN_CFG0 + 10'h004)
         rd_mux = chan_cfg_r[reg_addr[1:0] - 2'h2];
      else if (reg_addr == `ASC_OFF_MISC) rd_mux = {13'h0000, misc_r};
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (reset) reg_rdata <= 16'h0000;
      else reg_rdata <= reg_rd ? rd_mux : 16'h0000;
   end

   // External sync pin synchroniser
   always_ff @(posedge clk) begin
      if (reset) begin
         sync_q1_r <= 1'b0;
         sync_q2_r <= 1'b0;
      end else begin
         sync_q1_r <= ext_line_sync;
         sync_q2_r <= sync_q1_r;
      end
   end

   // Line sync source: internal count or qualified external level
   wire logic int_hit = (lcnt_r >= line_len_r);
   wire logic ext_hit = sync_q2_r && (xhi_cnt_r == `ASC_XSYNC_QUAL);
   wire logic sync_pick_nxt = sync_ext ? ext_hit : int_hit;
   wire logic sync_fall = sync_dly_r && !line_sync_r;

   // Line counter clears on its own pulse so each pulse is one cycle wide
   always_ff @(posedge clk) begin
      if (reset) begin
         lcnt_r <= 16'h0000;
         xhi_cnt_r <= 3'h0;
         line_sync_r <= 1'b0;
         sync_dly_r <= 1'b0;
      end else begin
         lcnt_r <= int_hit ? 16'h0000 : lcnt_r + 16'h0001;
         if (!sync_q2_r) xhi_cnt_r <= 3'h0;
         else if (xhi_cnt_r != `ASC_XSYNC_DONE) xhi_cnt_r <= xhi_cnt_r + 3'h1;
         line_sync_r <= sync_pick_nxt;
         sync_dly_r <= line_sync_r;
      end
   end
   assign line_sync = line_sync_r;

   // Pixel phase and pixel count from the sync falling edge
   wire logic ph_wrap = (ph_r >= pix_per_r - PIX_W'(1));
   always_ff @(posedge clk) begin
      if (reset) begin
         ph_r <= '0;
         pix_cnt_r <= 16'h0000;
      end else if (sync_fall) begin
         ph_r <= '0;
         pix_cnt_r <= 16'h0000;
      end else begin
         ph_r <= ph_wrap ? '0 : ph_r + PIX_W'(1);
         if (ph_wrap && pix_cnt_r != 16'hFFFF) pix_cnt_r <= pix_cnt_r + 16'h0001;
      end
   end

   // Sample pulse windows within the pixel period
   wire logic [PIX_W:0] ph_w = {1'b0, ph_r};
   wire logic ref_nxt = (ph_w >= (PIX_W+1)'(ref_start)) && (ph_w < (PIX_W+1)'(ref_start) + (PIX_W+1)'(ref_width));
   wire logic data_nxt = (ph_w >= (PIX_W+1)'(dat_start)) && (ph_w < (PIX_W+1)'(dat_start) + (PIX_W+1)'(dat_width));
   wire logic ref_rise = ref_nxt && !ref_r;
   wire logic in_win = (pix_cnt_r >= win_start_r) && (pix_cnt_r < win_end_r);
   wire logic win_nxt = !win_en || in_win;

   // Clamp pulse length: half the reference width, or the programmed end
   wire logic [PIX_W-1:0] half_ref = PIX_W'(ref_width >> 1);
   wire logic [PIX_W-1:0] auto_len = (half_ref == '0) ? PIX_W'(1) : half_ref;
   wire logic [PIX_W-1:0] man_len = (clp_end_r == '0) ? PIX_W'(1) : clp_end_r;
   wire logic [PIX_W-1:0] clp_len = auto_dis ? man_len : auto_len;
   wire logic clp_nxt = ref_rise || (clp_on_r && clp_cnt_r < clp_len);

   // Pulse generator; one register stage keeps all outputs aligned
   always_ff @(posedge clk) begin
      if (reset) begin
         ref_r <= 1'b0;
         data_r <= 1'b0;
         clp_on_r <= 1'b0;
         clp_cnt_r <= '0;
         win_r <= 1'b1;
      end else begin
         ref_r <= ref_nxt;
         data_r <= data_nxt;
         clp_on_r <= clp_nxt;
         clp_cnt_r <= ref_rise ? PIX_W'(1) : clp_cnt_r + PIX_W'(1);
         win_r <= win_nxt;
      end
   end
   assign clamp_window = win_r;

   // Group pulses only run when a channel of that group is in pixel clamp
   wire logic [1:0] grp_pix;
   assign grp_pix[0] = (clp_sel_r[0][1:0] == asc_pkg::ASC_CLP_PIXEL)
                    || (clp_sel_r[0][9:8] == asc_pkg::ASC_CLP_PIXEL);
   assign grp_pix[1] = (clp_sel_r[1][1:0] == asc_pkg::ASC_CLP_PIXEL)
                    || (clp_sel_r[1][9:8] == asc_pkg::ASC_CLP_PIXEL);
   assign clamp_pulse_group_a = clp_on_r && grp_pix[0];
   assign clamp_pulse_group_b = clp_on_r && grp_pix[1];
   assign ref_sample_pulse = {2{ref_r}};
   assign data_sample_pulse = {2{data_r}};

   // Per-channel control, registered from next-cycle pulse values
   generate
      for (g = 0; g < 4; g++) begin : g_chan
         wire logic [7:0] sel = clp_field(clp_sel_r[0], clp_sel_r[1], g);
         wire asc_pkg::asc_clp_mode_t mode = asc_pkg::asc_clp_mode_t'(sel[1:0]);
         wire logic is_hold = chan_cfg_r[g][`ASC_CFG_HOLD];
         logic clamp_nxt;
         // Line clamp is refused in sample-hold: droop over a line is too large
         always_comb begin
            case (mode)
               asc_pkg::ASC_CLP_PIXEL: clamp_nxt = win_nxt ? ref_nxt : clp_nxt;
               asc_pkg::ASC_CLP_LINE: clamp_nxt = !is_hold && win_nxt && ref_nxt;
               default: clamp_nxt = 1'b0;
            endcase
         end
         always_ff @(posedge clk) begin
            if (reset) begin
               chan_ctl[g] <= '0;
            end else begin
               chan_ctl[g].polarity <= chan_cfg_r[g][`ASC_CFG_POL];
               chan_ctl[g].hold_mode <= is_hold;
               chan_ctl[g].black_ref_en <= chan_cfg_r[g][`ASC_CFG_BREF];
               chan_ctl[g].black_ref_ext <= (mode == asc_pkg::ASC_CLP_NONE_EXT);
               chan_ctl[g].clamp_mode <= mode;
               chan_ctl[g].level_src <= sel[3:2];
               chan_ctl[g].dac_sel <= sel[5:4];
               chan_ctl[g].gain <= chan_cfg_r[g][`ASC_CFG_GAIN_MSB:`ASC_CFG_GAIN_LSB];
               chan_ctl[g].clamp_on <= clamp_nxt;
               chan_ctl[g].ref_sample <= ref_nxt && !is_hold;
               chan_ctl[g].data_sample <= data_nxt;
            end
         end

         // Checks on each channel
         chk_hold_no_ref: assert property (@(posedge clk) disable iff (reset)
            chan_ctl[g].hold_mode |-> !chan_ctl[g].ref_sample) else $error("ref sample in sample-hold");
         chk_dual_ref: assert property (@(posedge clk) disable iff (reset)
            !chan_ctl[g].hold_mode && ref_r |-> chan_ctl[g].ref_sample) else $error("double sample ref missing");
         chk_line_hold_off: assert property (@(posedge clk) disable iff (reset)
            chan_ctl[g].hold_mode && chan_ctl[g].clamp_mode == asc_pkg::ASC_CLP_LINE |-> !chan_ctl[g].clamp_on)
            else $error("line clamp in sample-hold");
         chk_pix_win_ref: assert property (@(posedge clk) disable iff (reset)
            chan_ctl[g].clamp_mode == asc_pkg::ASC_CLP_PIXEL && clamp_window |-> chan_ctl[g].clamp_on == ref_r)
            else $error("pixel clamp in window not ref pulse");
         chk_unclamp_ref: assert property (@(posedge clk) disable iff (reset)
            chan_ctl[g].clamp_mode == asc_pkg::ASC_CLP_NONE_INT |-> !chan_ctl[g].black_ref_ext && !chan_ctl[g].clamp_on)
            else $error("unclamped internal mode wrong");
         chk_gain_write: assert property (@(posedge clk) disable iff (reset)
            reg_wr && reg_addr == `ASC_OFF_CHAN_CFG0 + 10'(g) |=> ##1 chan_ctl[g].gain == $past(reg_wdata[9:4], 2))
            else $error("gain code not applied");
      end
   endgenerate

   // Helper: measured high time of the clamp pulse
   logic [PIX_W-1:0] clp_meas_r;
   always_ff @(posedge clk) begin
      if (reset) clp_meas_r <= '0;
      else clp_meas_r <= clp_on_r ? clp_meas_r + PIX_W'(1) : '0;
   end

   chk_sync_one_cycle: assert property (@(posedge clk) disable iff (reset)
      line_sync |=> !line_sync) else $error("line sync longer than one cycle");
   chk_int_ls_period: assert property (@(posedge clk) disable iff (reset)
      !sync_ext && int_hit && !wr_misc |=> line_sync) else $error("internal line sync missing");
   chk_clp_start: assert property (@(posedge clk) disable iff (reset)
      $rose(ref_r) |-> clp_on_r) else $error("clamp pulse not at ref rise");
   chk_clp_width: assert property (@(posedge clk) disable iff (reset)
      $fell(clp_on_r) && $stable(pix_tim_r) && $stable(misc_r) && $stable(clp_end_r) && !$past(ref_rise)
      |-> $past(clp_meas_r) + PIX_W'(1) == clp_len) else $error("clamp pulse width wrong");
   chk_window_default: assert property (@(posedge clk) disable iff (reset)
      !win_en |=> clamp_window) else $error("clamp window not high by default");
   chk_window_span: assert property (@(posedge clk) disable iff (reset)
      win_en && (pix_cnt_r < win_start_r) |=> !clamp_window) else $error("window open before start");

   cov_line_sync: cover property (@(posedge clk) disable iff (reset) line_sync);
   cov_group_a_pulse: cover property (@(posedge clk) disable iff (reset) $rose(clamp_pulse_group_a));
   cov_win_open: cover property (@(posedge clk) disable iff (reset) win_en ##1 $rose(clamp_window));

endmodule // asc_sampling_clamp_ctrl

`default_nettype wire

// file: logic/asc_cfg.svh
// Register offsets, field positions, reset values and counts for the sampling and clamp control block
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH

// Register offsets (word index equals printed offset)
`define ASC_OFF_LINE_LEN 10'h007
`define ASC_OFF_WIN_START 10'h008
`define ASC_OFF_WIN_END 10'h009
`define ASC_OFF_CLP_END 10'h00A
`define ASC_OFF_PIX_TIM 10'h00B
`define ASC_OFF_PIX_PER 10'h00C
`define ASC_OFF_STATUS 10'h00D
`define ASC_OFF_PIX_CNT 10'h00E
`define ASC_OFF_CLP_SEL_LO 10'h010
`define ASC_OFF_CLP_SEL_HI 10'h011
`define ASC_OFF_CHAN_CFG0 10'h012
`define ASC_OFF_MISC 10'h18F

// Channel config fields
`define ASC_CFG_POL 0
`define ASC_CFG_HOLD 1
`define ASC_CFG_BREF 2
`define ASC_CFG_GAIN_LSB 4
`define ASC_CFG_GAIN_MSB 9

// Misc control bits
`define ASC_MISC_AUTO_DIS 0
`define ASC_MISC_WIN_EN 1
`define ASC_MISC_SYNC_SRC 2

// Reset values
`define ASC_RST_LINE_LEN 16'h1000
`define ASC_RST_PIX_TIM 16'h2420
`define ASC_RST_PIX_PER 8'h08
`define ASC_RST_CLP_END 8'h01
`define ASC_RST_ZERO16 16'h0000

// External line sync must be seen high this many cycles before a pulse is made
`define ASC_XSYNC_QUAL 3'h3
`define ASC_XSYNC_DONE 3'h4

`endif

// file: logic/asc_pkg.sv
// Types shared by the sampling and clamp control block
package asc_pkg;

   // Clamp mode select encoding per channel
   typedef enum logic [1:0] {
      ASC_CLP_PIXEL = 2'h0,
      ASC_CLP_LINE = 2'h1,
      ASC_CLP_NONE_INT = 2'h2,
      ASC_CLP_NONE_EXT = 2'h3
   } asc_clp_mode_t;

   // Per-channel control bundle toward the analog side
   typedef struct packed {
      logic polarity;
      logic hold_mode;
      logic black_ref_en;
      logic black_ref_ext;
      asc_clp_mode_t clamp_mode;
      logic [1:0] level_src;
      logic [1:0] dac_sel;
      logic [5:0] gain;
      logic clamp_on;
      logic ref_sample;
      logic data_sample;
   } asc_chan_t;

endpackage

// file: dv/asc_sync_source.sv
// Model of the sensor-side line sync source that drives the external sync pin
`timescale 1ns/10ps
`default_nettype none

module asc_sync_source (
   input wire logic clk,
   output logic ext_line_sync
);
   // Pin idles low between lines, the sync level is active high
   initial begin
      ext_line_sync = 1'b0;
   end

   // One sync level of a given length; short ones model glitches
   task automatic send(input int cycles);
      @(posedge clk);
      ext_line_sync <= 1'b1;
      repeat (cycles) @(posedge clk);
      ext_line_sync <= 1'b0;
   endtask
endmodule // asc_sync_source
`default_nettype wire

// file: dv/asc_sampling_clamp_ctrl_bench.sv
// Self-checking bench for the sampling and clamp control block
`timescale 1ns/10ps
`default_nettype none
`include "asc_cfg.svh"

module asc_sampling_clamp_ctrl_bench;
   logic clk;
   logic reset;
   logic [9:0] reg_addr;
   logic [15:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [15:0] reg_rdata;
   logic line_sync;
   logic clamp_window;
   logic [1:0] ref_sample_pulse;
   logic [1:0] data_sample_pulse;
   logic clamp_pulse_group_a;
   logic clamp_pulse_group_b;
   wire logic ext_line_sync;
   asc_pkg::asc_chan_t chan_ctl [4];
   logic [8:0] obs;
   logic [8:0] prev_obs;
   logic [15:0] rv;
   logic [15:0] sb;
   int c;
   int err_count;
   int tests_run;
   logic [9:0] offs [5] = '{`ASC_OFF_LINE_LEN, `ASC_OFF_WIN_START, `ASC_OFF_WIN_END,
                           `ASC_OFF_CLP_SEL_LO, `ASC_OFF_CLP_SEL_HI};
   logic [15:0] pats [5] = '{16'h004F, 16'h0002, 16'h0005, 16'h3924, 16'h0B12};
   logic [15:0] cfgs [4] = '{16'h0001, 16'h07F2, 16'h0156, 16'h02A1};
   logic [15:0] gains [4] = '{16'h0000, 16'h003F, 16'h0015, 16'h002A};

   // Watched outputs gathered so one set of tasks serves all of them
   assign obs = {chan_ctl[1].data_sample, chan_ctl[1].ref_sample, chan_ctl[1].clamp_on, line_sync,
                 clamp_window, clamp_pulse_group_b, clamp_pulse_group_a, data_sample_pulse[0],
                 ref_sample_pulse[0]};

   // Free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   asc_sampling_clamp_ctrl dut (
      .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_line_sync(ext_line_sync), .line_sync(line_sync),
      .clamp_window(clamp_window), .ref_sample_pulse(ref_sample_pulse),
      .data_sample_pulse(data_sample_pulse), .clamp_pulse_group_a(clamp_pulse_group_a),
      .clamp_pulse_group_b(clamp_pulse_group_b), .chan_ctl(chan_ctl)
   );

   asc_sync_source src (
      .clk(clk),
      .ext_line_sync(ext_line_sync)
   );

   // Verdict and end of run, also reached from the wait_rise timeout
   task automatic close_out();
      $display("Checks %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t %s: got %h exp %h", $time, what, got, exp);
      end
   endtask

   // One-cycle write strobe, dropped at the edge that takes it
   task automatic wr(input logic [9:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [9:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   // High cycles of one watched output over a fixed span
   task automatic cnt(input int idx, input int n, output int k);
      k = 0;
      repeat (n) begin
         @(posedge clk);
         #1;
         k += int'(obs[idx]);
      end
   endtask

   // Bounded wait for a rising edge; prev_obs keeps the cycle before
   task automatic wait_rise(input int idx);
      int t;
      t = 0;
      do begin
         prev_obs = obs;
         @(posedge clk);
         #1;
         t++;
      end while (!(prev_obs[idx] === 1'b0 && obs[idx] === 1'b1) && t < 400);
      if (t >= 400) begin
         err_count++;
         $display("ERROR t=%0t no rising edge on watch %0d", $time, idx);
         close_out();
      end
   endtask

   // Length of the high pulse that has just risen
   task automatic width(input int idx, output int w);
      w = 1;
      while (obs[idx] === 1'b1 && w < 300) begin
         @(posedge clk);
         #1;
         if (obs[idx] === 1'b1) w++;
      end
   endtask

   // Main sequence of tests
   initial begin
      reset = 1'b1;
      reg_addr = 10'h000;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      err_count = 0;
      tests_run = 0;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      #1;
      chk(16'(clamp_window), 16'h0001, "window after reset");
      rd(`ASC_OFF_LINE_LEN, rv);
      chk(rv, `ASC_RST_LINE_LEN, "line length reset");
      rd(`ASC_OFF_MISC, rv);
      chk(rv, 16'h0000, "misc reset");
      $display("Test reset values done");
      for (int i = 0; i < 5; i++) begin
         wr(offs[i], pats[i]);
         rd(offs[i], rv);
         chk(rv, pats[i], "register readback");
      end
      rd(10'h3FE, rv);
      chk(rv, 16'h0000, "unmapped read");
      // Channel 3 unclamped on internal level gets its black reference enabled
      for (int i = 0; i < 4; i++) wr(`ASC_OFF_CHAN_CFG0 + 10'(i), cfgs[i]);
      repeat (3) @(posedge clk);
      #1;
      for (int i = 0; i < 4; i++) begin
         sb = (i < 2 ? pats[3] : pats[4]) >> (8 * (i % 2));
         chk(16'(chan_ctl[i].polarity), 16'(cfgs[i][0]), "polarity");
         chk(16'(chan_ctl[i].hold_mode), 16'(cfgs[i][1]), "sampling mode");
         chk(16'(chan_ctl[i].black_ref_en), 16'(cfgs[i][2]), "black reference enable");
         chk(16'(chan_ctl[i].black_ref_ext), 16'(sb[1:0] == 2'h3), "external ground reference");
         chk(16'(chan_ctl[i].gain), gains[i], "gain");
         chk(16'(chan_ctl[i].clamp_mode), 16'(sb[1:0]), "clamp mode");
         chk(16'(chan_ctl[i].level_src), 16'(sb[3:2]), "level source");
         chk(16'(chan_ctl[i].dac_sel), 16'(sb[5:4]), "dac level");
      end
      $display("Test channel setup done");
      wr(`ASC_OFF_MISC, 16'h0004);
      wait_rise(5);
      cnt(5, 80, c);
      chk(16'(c), 16'h0001, "one sync per line");
      cnt(4, 80, c);
      chk(16'(c), 16'h0050, "window idle high");
      // Window state defined right after the sync source
      wr(`ASC_OFF_MISC, 16'h0006);
      wait_rise(5);
      cnt(4, 80, c);
      chk(16'(c), 16'h0018, "window length");
      $display("Test line timing done");
      for (int i = 0; i < 4; i++) wr(`ASC_OFF_CHAN_CFG0 + 10'(i), 16'h0000);
      wr(`ASC_OFF_CLP_SEL_LO, 16'h0100);
      wr(`ASC_OFF_CLP_SEL_HI, 16'h0202);
      // Reference pulse ends where the data pulse begins, never overlapping
      wr(`ASC_OFF_PIX_TIM, 16'h2440);
      wait_rise(5);
      wait_rise(0);
      chk(16'(obs[1]), 16'h0000, "data quiet at ref rise");
      chk(16'({ref_sample_pulse, data_sample_pulse}), 16'h000C, "both groups ref pulse");
      width(0, c);
      chk(16'(c), 16'h0004, "ref width");
      chk(16'(obs[1]), 16'h0001, "data follows ref");
      wait_rise(2);
      chk(16'({prev_obs[0], obs[0]}), 16'h0001, "clamp starts at ref rise");
      width(2, c);
      chk(16'(c), 16'h0002, "auto clamp width");
      cnt(3, 80, c);
      chk(16'(c), 16'h0000, "group b idle");
      cnt(6, 80, c);
      chk(16'(c), 16'h000C, "line clamp in window");
      wr(`ASC_OFF_CLP_END, 16'h0003);
      wr(`ASC_OFF_MISC, 16'h0007);
      wait_rise(5);
      wait_rise(2);
      width(2, c);
      chk(16'(c), 16'h0003, "manual clamp width");
      wr(`ASC_OFF_CLP_SEL_HI, 16'h0200);
      cnt(3, 80, c);
      chk(16'(c > 0), 16'h0001, "group b serves channel 3");
      wr(`ASC_OFF_CHAN_CFG0 + 10'h001, 16'h0002);
      repeat (3) @(posedge clk);
      cnt(6, 80, c);
      chk(16'(c), 16'h0000, "no line clamp in sample-hold");
      cnt(7, 80, c);
      chk(16'(c), 16'h0000, "no ref sample in sample-hold");
      cnt(8, 80, c);
      chk(16'(c > 0), 16'h0001, "data sample in sample-hold");
      $display("Test pixel pulses done");
      // External sync source with the window enabled
      wr(`ASC_OFF_MISC, 16'h0002);
      repeat (100) @(posedge clk);
      fork
         src.send(2);
         cnt(4, 30, c);
      join
      chk(16'(c), 16'h0000, "short sync ignored");
      fork
         src.send(8);
         cnt(4, 100, c);
      join
      chk(16'(c), 16'h0018, "window after external sync");
      $display("Test external sync done");
      close_out();
   end
endmodule // asc_sampling_clamp_ctrl_bench
`default_nettype wire
